// *** hdl/mardc_pdm.sv ***
`include "mardc_consts.svh"
module mardc_pdm
	import mardc_pkg::*;
	(
	// Clock and reset
	input wire logic clk,
	input wire logic srst,
	// Code and enable
	input wire logic enable,
	input wire logic [9:0] code,
	// Pin
	output logic pdm_out,
	output logic pdm_oe
	);
	mardc_pdm_state_type s;
	mardc_pdm_state_type next_s;
	logic [10:0] sum;

	// First order delta-sigma, carry is the output pulse
	always_comb
	begin
		next_s = s;
		sum = {1'b0, s.acc} + {1'b0, code};
		next_s.acc = enable ? sum[9:0] : 10'h000;
		next_s.out = enable & sum[10];
		next_s.oe = enable;
	end

	always_ff @(posedge clk)
	begin
		if (srst)
			s <= '0;
		else
			s <= next_s;
	end

	assign pdm_out = s.out;
	assign pdm_oe = s.oe;
endmodule // mardc_pdm

// *** hdl/mardc_range.sv ***
`include "mardc_consts.svh"
module mardc_range
	import mardc_pkg::*;
	(
	// Clock and reset
	input wire logic clk,
	input wire logic srst,
	// Slot and settings
	input wire logic slot,
	input wire mardc_rcfg_type cfg,
	input wire mardc_conv_type fine_set,
	input wire mardc_conv_type coarse_set,
	// Converter
	output logic conv_req,
	output mardc_conv_type conv_set,
	input wire logic conv_done,
	input wire logic [15:0] conv_raw,
	// Result
	output logic [15:0] result,
	output logic range_used_flag,
	output logic done
	);
	mardc_rng_state_type s;
	mardc_rng_state_type next_s;
	logic [15:0] fine;
	logic [15:0] fine_max;
	logic [15:0] coarse_min;
	logic go_coarse;

	// Thresholds follow the shift count
	always_comb
	begin
		fine = conv_raw >> fine_set.shift;
		fine_max = `MARDC_FINE_MAX0 >> fine_set.shift;
		coarse_min = `MARDC_COARSE_MIN0 >> fine_set.shift;
		if (cfg.force_fine_select)
			go_coarse = 1'b0;
		else if (cfg.crossover)
			go_coarse = fine >= fine_max;
		else if (s.last_coarse)
			go_coarse = fine >= coarse_min;
		else
			go_coarse = fine >= fine_max;
	end

	// Slot sequencer
	always_comb
	begin
		next_s = s;
		next_s.req = 1'b0;
		next_s.done = 1'b0;
		unique case (s.st)
			RNG_IDLE:
				if (slot)
				begin
					next_s.req = 1'b1;
					if (cfg.force_coarse_select && !cfg.force_fine_select)
					begin
						next_s.st = RNG_COARSE;
						next_s.set = coarse_set;
					end
					else
					begin
						next_s.st = RNG_FINE;
						next_s.set = fine_set;
					end
				end
			RNG_FINE:
				if (conv_done)
				begin
					if (go_coarse)
					begin
						next_s.st = RNG_COARSE;
						next_s.req = 1'b1;
						next_s.set = coarse_set;
						next_s.set.shift = 3'h0;
					end
					else
					begin
						next_s.st = RNG_IDLE;
						next_s.result = fine;
						next_s.range_used_flag = 1'b0;
						next_s.last_coarse = 1'b0;
						next_s.done = 1'b1;
					end
				end
			RNG_COARSE:
				if (conv_done)
				begin
					next_s.st = RNG_IDLE;
					next_s.result = conv_raw;
					next_s.range_used_flag = 1'b1;
					next_s.last_coarse = 1'b1;
					next_s.done = 1'b1;
				end
			default:
				next_s.st = RNG_IDLE;
		endcase
	end

	always_ff @(posedge clk)
	begin
		if (srst)
			s <= '0;
		else
			s <= next_s;
	end

	assign conv_req = s.req;
	assign conv_set = s.set;
	assign result = s.result;
	assign range_used_flag = s.range_used_flag;
	assign done = s.done;
endmodule // mardc_range

// *** hdl/mardc_top.sv ***
// Summary of operation
// - Each third-channel slot starts with a fine conversion using fine settings, or coarse when only coarse is forced.
// - Report fine result, or convert again coarse, unshifted, same slot.
// - Fine result meets one of two thresholds, chosen by last range.
// - Fine maximum and coarse minimum scale down with the shift count.
// - Two bits force fine or coarse; both clear means auto-ranging.
// - Crossover mode switches ranges at one point without hysteresis.
// - Without crossover, hysteresis at the boundary stops chatter.
// - One result register for both ranges plus a range indicator bit.
// - Before first analog-level power, outputs off and shadow settings zero.
// - At analog level recall shadow settings, enable analog, then run.
// - Brown-out keeps settings, disables analog and outputs, resumes at once.
// - Below digital level all state but the tables defaults; recall repeats next power-up.
// - Not-ready reads one below analog level, clears 500 us after recall completes.
// - Answer on default address A2h until the stored address is recalled.
// - Power-on sets supply-low alarm; cleared by supply conversion above limit.
// - Transmit fault never latches before a supply conversion above limit.
// - Power-on alarm unmaskable; transmit fault asserted below analog level.
// - Four pulse-density outputs driven from 10-bit codes.
// - Codes come from manual value or lookup; bias also from loop.
// - Pulse-density pins stay high impedance until the init delay ends.
// - Lookup code is table entry plus four times offset table entry.
// - Swing and first aux tables step 2 C; second aux 4 C.
// - Offset tables sit in bytes F8h-FFh of each table page.
// - Temperature-driven codes refresh after every temperature conversion.
`include "mardc_consts.svh"
module mardc_top
	import mardc_pkg::*;
	#(
	parameter int INIT_CYCLES = `MARDC_INIT_US * `MARDC_CLK_MHZ
	)
	(
	// Clock and reset
	input wire logic CLK,
	input wire logic SRST,
	// Supply detection and recall
	input wire logic SUPPLY_ABOVE_ANALOG,
	output logic RECALL_REQ,
	input wire logic RECALL_DONE,
	output logic ANALOG_ENABLE,
	output logic [7:0] DEVICE_ADDR,
	// Register port
	input wire logic [7:0] REG_PAGE,
	input wire logic [7:0] REG_ADDR,
	input wire logic REG_WR,
	input wire logic REG_RD,
	input wire logic [7:0] REG_WDATA,
	output logic [7:0] REG_RDATA,
	// Third channel converter
	input wire logic THIRD_MONITOR_CHANNEL_SLOT,
	output logic CONV_REQ,
	output mardc_conv_type CONV_SET,
	input wire logic CONV_DONE,
	input wire logic [15:0] CONV_RAW,
	// Supply and temperature conversions
	input wire logic VCC_CONV_DONE,
	input wire logic [15:0] VCC_CONV_VALUE,
	input wire logic TEMP_CONV_DONE,
	input wire logic [15:0] TEMP_VALUE,
	// Fault and loop
	input wire logic FAULT_IN,
	input wire logic [9:0] LOOP_CODE,
	output logic TX_FAULT,
	output logic SUPPLY_LOW_ALARM,
	// Pulse-density pins
	output logic [3:0] PDM_OUT,
	output logic [3:0] PDM_OE
	);
	typedef struct packed {
		mardc_pwr_type pwr;
		logic recalled;
		logic [`MARDC_TIMER_W-1:0] timer;
		logic init_done;
		logic not_ready;
		logic low_alarm;
		logic vcc_ok;
		logic fault_latch;
		logic tx_fault;
		logic analog_en;
		logic recall_req;
		logic [7:0] addr_out;
		logic [7:0] cfg_c;
		logic [7:0] shift;
		logic [7:0] dev_addr;
		logic [7:0] mode;
		logic [15:0] fgain;
		logic [15:0] cgain;
		logic [15:0] fofs;
		logic [15:0] cofs;
		logic [15:0] vcc_lim;
		logic [3:0][9:0] manual;
		logic [3:0][9:0] code;
		logic [7:0] temp;
		logic temp_new;
		logic [15:0] result;
		logic range_flag;
		logic [7:0] rdata;
	} mardc_top_state_type;

	localparam logic [`MARDC_TIMER_W-1:0] INIT_LAST =
		`MARDC_TIMER_W'(INIT_CYCLES - 1);

	mardc_top_state_type s;
	mardc_top_state_type next_s;
	logic [7:0] lut [4][128];
	logic [6:0] hr_idx [4];
	logic [6:0] of_idx;
	logic [3:0][9:0] lut_code;
	logic cfg_page;
	logic run;
	logic rng_done;
	logic [15:0] rng_result;
	logic rng_flag;
	mardc_rcfg_type rcfg;
	mardc_conv_type fine_set;
	mardc_conv_type coarse_set;

	// Table index from whole degrees, saturating at both ends
	function automatic logic [6:0] lut_index(input logic [7:0] deg,
		input int step, input int entries);
		logic signed [9:0] v;
		int q;
		v = $signed({{2{deg[7]}}, deg}) + 10'sd`MARDC_TEMP_ORIGIN;
		q = (v < 0) ? 0 : int'(v) / step;
		if (q > entries - 1)
			q = entries - 1;
		return 7'(q);
	endfunction

	assign cfg_page = REG_PAGE == `MARDC_PAGE_CFG;
	assign run = s.pwr == PWR_RUN;

	// Range controls and calibration sets
	always_comb
	begin
		rcfg.force_fine_select = s.cfg_c[`MARDC_BIT_FF];
		rcfg.force_coarse_select = s.cfg_c[`MARDC_BIT_FC];
		rcfg.crossover = s.cfg_c[`MARDC_BIT_XOVER];
		fine_set = '{gain: s.fgain, offset: s.fofs, shift: s.shift[2:0]};
		coarse_set = '{gain: s.cgain, offset: s.cofs, shift: 3'h0};
	end

	mardc_range u_range (
		.clk(CLK),
		.srst(SRST),
		.slot(THIRD_MONITOR_CHANNEL_SLOT & run),
		.cfg(rcfg),
		.fine_set(fine_set),
		.coarse_set(coarse_set),
		.conv_req(CONV_REQ),
		.conv_set(CONV_SET),
		.conv_done(CONV_DONE),
		.conv_raw(CONV_RAW),
		.result(rng_result),
		.range_used_flag(rng_flag),
		.done(rng_done)
	);

	// Lookup sums from captured temperature
	always_comb
	begin
		hr_idx[0] = lut_index(s.temp, `MARDC_STEP_FINE,
			`MARDC_ENT_FINE);
		hr_idx[1] = lut_index(s.temp, `MARDC_STEP_WIDE, `MARDC_ENT_WIDE);
		hr_idx[2] = lut_index(s.temp, `MARDC_STEP_FINE,
			`MARDC_ENT_FINE);
		hr_idx[3] = lut_index(s.temp, `MARDC_STEP_WIDE,
			`MARDC_ENT_WIDE);
		of_idx = `MARDC_OFS_LUT + lut_index(s.temp, `MARDC_OFS_STEP,
			`MARDC_OFS_ENTRIES);
		for (int i = 0; i < 4; i++)
		begin
			logic [10:0] sum;
			sum = {3'h0, lut[i][hr_idx[i]]}
				+ {1'b0, lut[i][of_idx], 2'h0};
			lut_code[i] = sum > 11'(`MARDC_CODE_MAX) ? `MARDC_CODE_MAX
				: sum[9:0];
		end
	end

	// Table storage, writable once power has reached the analog level
	always_ff @(posedge CLK)
	begin
		if (REG_WR && REG_ADDR[7] && s.pwr != PWR_OFF
			&& REG_PAGE[7:2] == `MARDC_PAGE_LUT0 >> 2)
			lut[REG_PAGE[1:0]][REG_ADDR[6:0]] <= REG_WDATA;
	end

	// Power sequencing, alarms, registers and output codes
	always_comb
	begin
		next_s = s;
		next_s.temp_new = 1'b0;
		unique case (s.pwr)
			PWR_OFF:
				if (SUPPLY_ABOVE_ANALOG)
				begin
					next_s.pwr = PWR_RECALL;
					next_s.recall_req = 1'b1;
				end
			PWR_RECALL:
				if (!SUPPLY_ABOVE_ANALOG)
				begin
					next_s.pwr = PWR_OFF;
					next_s.recall_req = 1'b0;
				end
				else if (RECALL_DONE)
				begin
					next_s.pwr = PWR_RUN;
					next_s.recall_req = 1'b0;
					next_s.recalled = 1'b1;
					next_s.analog_en = 1'b1;
				end
			PWR_RUN:
				if (!SUPPLY_ABOVE_ANALOG)
				begin
					next_s.pwr = PWR_BROWN;
					next_s.analog_en = 1'b0;
				end
			PWR_BROWN:
				if (SUPPLY_ABOVE_ANALOG)
				begin
					next_s.pwr = PWR_RUN;
					next_s.analog_en = 1'b1;
				end
		endcase
		// Init delay runs once per power-up
		if (run && !s.init_done)
		begin
			next_s.timer = s.timer + 1'b1;
			if (s.timer == INIT_LAST)
				next_s.init_done = 1'b1;
		end
		next_s.not_ready = !(run && s.init_done);
		next_s.addr_out = s.recalled ? s.dev_addr
			: `MARDC_DEF_ADDR;
		// Supply-low alarm and transmit fault
		if (!run)
		begin
			next_s.low_alarm = 1'b1;
			next_s.vcc_ok = 1'b0;
		end
		else if (VCC_CONV_DONE && VCC_CONV_VALUE > s.vcc_lim)
		begin
			next_s.low_alarm = 1'b0;
			next_s.vcc_ok = 1'b1;
		end
		if (!s.cfg_c[`MARDC_BIT_LATCH])
			next_s.fault_latch = 1'b0;
		else if (FAULT_IN && s.vcc_ok)
			next_s.fault_latch = 1'b1;
		next_s.tx_fault = !run || (s.cfg_c[`MARDC_BIT_LATCH]
			? s.fault_latch : FAULT_IN);
		// Third channel result
		if (rng_done)
		begin
			next_s.result = rng_result;
			next_s.range_flag = rng_flag;
		end
		// Temperature capture, codes follow one cycle later
		if (TEMP_CONV_DONE && run)
		begin
			next_s.temp = TEMP_VALUE[15:8];
			next_s.temp_new = 1'b1;
		end
		for (int i = 0; i < 4; i++)
		begin
			if (s.mode[2*i +: 2] == `MARDC_MODE_LUT)
			begin
				if (s.temp_new)
					next_s.code[i] = lut_code[i];
			end
			else if (i == 1 && s.mode[2*i +: 2] == `MARDC_MODE_LOOP)
				next_s.code[i] = LOOP_CODE;
			else
				next_s.code[i] = s.manual[i];
		end
		// Shadow settings take writes only after power-up starts
		if (REG_WR && s.pwr != PWR_OFF && cfg_page)
		begin
			unique case (REG_ADDR)
				`MARDC_OFS_MODE: next_s.mode = REG_WDATA;
				`MARDC_OFS_CFG_C: next_s.cfg_c = REG_WDATA;
				`MARDC_OFS_DEVADDR: next_s.dev_addr = REG_WDATA;
				`MARDC_OFS_SHIFT: next_s.shift = REG_WDATA;
				`MARDC_OFS_FGAIN: next_s.fgain[15:8] = REG_WDATA;
				`MARDC_OFS_FGAIN + 8'h01: next_s.fgain[7:0] = REG_WDATA;
				`MARDC_OFS_CGAIN: next_s.cgain[15:8] = REG_WDATA;
				`MARDC_OFS_CGAIN + 8'h01: next_s.cgain[7:0] = REG_WDATA;
				`MARDC_OFS_FOFS: next_s.fofs[15:8] = REG_WDATA;
				`MARDC_OFS_FOFS + 8'h01: next_s.fofs[7:0] = REG_WDATA;
				`MARDC_OFS_COFS: next_s.cofs[15:8] = REG_WDATA;
				`MARDC_OFS_COFS + 8'h01: next_s.cofs[7:0] = REG_WDATA;
				`MARDC_OFS_VCCLIM: next_s.vcc_lim[15:8] = REG_WDATA;
				`MARDC_OFS_VCCLIM + 8'h01: next_s.vcc_lim[7:0] = REG_WDATA;
				default:
				begin
				end
			endcase
			for (int i = 0; i < 4; i++)
			begin
				if (REG_ADDR == `MARDC_OFS_MANUAL + 8'(2 * i))
					next_s.manual[i][9:8] = REG_WDATA[1:0];
				if (REG_ADDR == `MARDC_OFS_MANUAL + 8'(2 * i + 1))
					next_s.manual[i][7:0] = REG_WDATA;
			end
		end
		// Read data
		if (REG_RD)
		begin
			next_s.rdata = 8'h00;
			if (!REG_ADDR[7])
			begin
				unique case (REG_ADDR)
					`MARDC_OFS_RESULT: next_s.rdata = s.result[15:8];
					`MARDC_OFS_RESULT + 8'h01: next_s.rdata = s.result[7:0];
					`MARDC_OFS_STATUS:
					begin
						next_s.rdata[`MARDC_BIT_NRDY] = s.not_ready;
						next_s.rdata[`MARDC_BIT_TXF] = s.tx_fault;
						next_s.rdata[`MARDC_BIT_LOWA] = s.low_alarm;
					end
					`MARDC_OFS_UPDATE:
						next_s.rdata[`MARDC_BIT_RANGE] = s.range_flag;
					default:
					begin
					end
				endcase
			end
			else if (cfg_page)
			begin
				unique case (REG_ADDR)
					`MARDC_OFS_MODE: next_s.rdata = s.mode;
					`MARDC_OFS_CFG_C: next_s.rdata = s.cfg_c;
					`MARDC_OFS_DEVADDR: next_s.rdata = s.dev_addr;
					`MARDC_OFS_SHIFT: next_s.rdata = s.shift;
					`MARDC_OFS_FGAIN: next_s.rdata = s.fgain[15:8];
					`MARDC_OFS_FGAIN + 8'h01: next_s.rdata = s.fgain[7:0];
					`MARDC_OFS_CGAIN: next_s.rdata = s.cgain[15:8];
					`MARDC_OFS_CGAIN + 8'h01: next_s.rdata = s.cgain[7:0];
					`MARDC_OFS_FOFS: next_s.rdata = s.fofs[15:8];
					`MARDC_OFS_FOFS + 8'h01: next_s.rdata = s.fofs[7:0];
					`MARDC_OFS_COFS: next_s.rdata = s.cofs[15:8];
					`MARDC_OFS_COFS + 8'h01: next_s.rdata = s.cofs[7:0];
					`MARDC_OFS_VCCLIM: next_s.rdata = s.vcc_lim[15:8];
					`MARDC_OFS_VCCLIM + 8'h01: next_s.rdata = s.vcc_lim[7:0];
					default:
					begin
					end
				endcase
			end
			else if (REG_PAGE[7:2] == `MARDC_PAGE_LUT0 >> 2)
				next_s.rdata = lut[REG_PAGE[1:0]][REG_ADDR[6:0]];
		end
	end

	// Loss of the digital level resets all working state, setting not-ready, alarm and fault and the default address
	always_ff @(posedge CLK)
	begin
		if (SRST)
		begin
			s <= '0;
			s.not_ready <= 1'b1;
			s.low_alarm <= 1'b1;
			s.tx_fault <= 1'b1;
			s.addr_out <= `MARDC_DEF_ADDR;
		end
		else
			s <= next_s;
	end

	// Four pulse-density outputs
	for (genvar g = 0; g < 4; g++)
	begin : g_pdm
		mardc_pdm u_pdm (
			.clk(CLK),
			.srst(SRST),
			.enable(s.init_done & s.analog_en),
			.code(s.code[g]),
			.pdm_out(PDM_OUT[g]),
			.pdm_oe(PDM_OE[g])
		);
	end

	assign RECALL_REQ = s.recall_req;
	assign ANALOG_ENABLE = s.analog_en;
	assign DEVICE_ADDR = s.addr_out;
	assign REG_RDATA = s.rdata;
	assign TX_FAULT = s.tx_fault;
	assign SUPPLY_LOW_ALARM = s.low_alarm;
endmodule // mardc_top

// *** inc/mardc_consts.svh ***
`ifndef MARDC_CONSTS_SVH
`define MARDC_CONSTS_SVH
// Lower memory offsets
`define MARDC_OFS_RESULT 8'h68
`define MARDC_OFS_STATUS 8'h6e
`define MARDC_OFS_UPDATE 8'h6f
// Configuration page offsets
`define MARDC_OFS_MODE 8'h80
`define MARDC_OFS_CFG_C 8'h8b
`define MARDC_OFS_DEVADDR 8'h8c
`define MARDC_OFS_SHIFT 8'h8f
`define MARDC_OFS_FGAIN 8'h98
`define MARDC_OFS_CGAIN 8'h9c
`define MARDC_OFS_FOFS 8'ha8
`define MARDC_OFS_COFS 8'hac
`define MARDC_OFS_MANUAL 8'hb0
`define MARDC_OFS_VCCLIM 8'hb8
// Pages
`define MARDC_PAGE_CFG 8'h02
`define MARDC_PAGE_LUT0 8'h04
// Field positions
`define MARDC_BIT_FF 0
`define MARDC_BIT_FC 1
`define MARDC_BIT_XOVER 2
`define MARDC_BIT_LATCH 3
`define MARDC_BIT_NRDY 0
`define MARDC_BIT_TXF 1
`define MARDC_BIT_LOWA 2
`define MARDC_BIT_RANGE 0
// Values
`define MARDC_FINE_MAX0 16'hfff8
`define MARDC_COARSE_MIN0 16'hf000
`define MARDC_DEF_ADDR 8'ha2
`define MARDC_CODE_MAX 10'h3ff
`define MARDC_MODE_MANUAL 2'h0
`define MARDC_MODE_LUT 2'h1
`define MARDC_MODE_LOOP 2'h2
// Lookup table geometry
`define MARDC_TEMP_ORIGIN 40
`define MARDC_OFS_LUT 7'h78
`define MARDC_OFS_STEP 20
`define MARDC_OFS_ENTRIES 8
`define MARDC_STEP_FINE 2
`define MARDC_STEP_WIDE 4
`define MARDC_ENT_FINE 72
`define MARDC_ENT_WIDE 36
// Timing
`define MARDC_INIT_US 500
`define MARDC_CLK_MHZ 200
`define MARDC_TIMER_W 17
`endif

// *** inc/mardc_pkg.sv ***
package mardc_pkg;
	typedef enum logic [1:0] {PWR_OFF, PWR_RECALL, PWR_RUN, PWR_BROWN}
		mardc_pwr_type;
	typedef enum logic [1:0] {RNG_IDLE, RNG_FINE, RNG_COARSE}
		mardc_rng_type;
	// Calibration set handed to the converter
	typedef struct packed {
		logic [15:0] gain;
		logic [15:0] offset;
		logic [2:0] shift;
	} mardc_conv_type;
	// Range selection controls
	typedef struct packed {
		logic force_fine_select;
		logic force_coarse_select;
		logic crossover;
	} mardc_rcfg_type;
	typedef struct packed {
		mardc_rng_type st;
		logic last_coarse;
		logic req;
		mardc_conv_type set;
		logic [15:0] result;
		logic range_used_flag;
		logic done;
	} mardc_rng_state_type;
	typedef struct packed {
		logic [9:0] acc;
		logic out;
		logic oe;
	} mardc_pdm_state_type;
endpackage

// *** tb/mardc_conv_model.sv ***
module mardc_conv_model
	import mardc_pkg::*;
	#(
	parameter int LAG = 3
	)
	(
	// Clock
	input wire logic clk,
	// Request from the device
	input wire logic req,
	input wire mardc_conv_type set,
	// Input levels for the two ranges
	input wire logic [15:0] fine_gain,
	input wire logic [15:0] fine_level,
	input wire logic [15:0] coarse_level,
	// Answer
	output logic done,
	output logic [15:0] raw
	);
	timeunit 1ns;
	timeprecision 100ps;
	int cnt = 0;
	initial
	begin
		done = 1'b0;
		raw = 16'h5a5a;
	end
	// Answer LAG cycles after a request; raw is garbage when not valid
	always @(posedge clk)
	begin
		done <= (cnt == 1);
		if (cnt == 1)
			raw <= (set.gain == fine_gain) ? fine_level : coarse_level;
		else
			raw <= ~raw;
		cnt <= req ? LAG : (cnt > 0 ? cnt - 1 : 0);
	end
endmodule // mardc_conv_model

// *** tb/mardc_props.sv ***
module mardc_props
	import mardc_pkg::*;
	#(
	parameter int INIT_CYCLES = 20
	)
	(
	// Clock and reset
	input wire logic CLK,
	input wire logic SRST,
	// Power and recall
	input wire logic SUPPLY_ABOVE_ANALOG,
	input wire logic RECALL_REQ,
	input wire logic RECALL_DONE,
	input wire logic ANALOG_ENABLE,
	input wire logic [7:0] DEVICE_ADDR,
	// Converter, alarms and pins
	input wire logic THIRD_MONITOR_CHANNEL_SLOT,
	input wire logic CONV_REQ,
	input wire mardc_conv_type CONV_SET,
	input wire logic CONV_DONE,
	input wire logic VCC_CONV_DONE,
	input wire logic TX_FAULT,
	input wire logic SUPPLY_LOW_ALARM,
	input wire logic [3:0] PDM_OE
	);
	timeunit 1ns;
	timeprecision 100ps;
	int run_cnt;
	logic seen_run;
	default clocking @(posedge CLK); endclocking
	default disable iff (SRST);
	// Running time since reset; a brown-out does not restart it
	always_ff @(posedge CLK)
	begin
		if (SRST)
		begin
			run_cnt <= 0;
			seen_run <= 1'b0;
		end
		else if (ANALOG_ENABLE)
		begin
			run_cnt <= run_cnt + 1;
			seen_run <= 1'b1;
		end
	end
	a_req_single: assert property (
		CONV_REQ |=> !CONV_REQ) else $error("request longer than a cycle");
	a_req_cause: assert property (
		CONV_REQ |-> $past(THIRD_MONITOR_CHANNEL_SLOT) || $past(CONV_DONE))
		else $error("request without slot or result");
	a_coarse_unshifted: assert property (
		CONV_REQ && $past(CONV_DONE) |-> CONV_SET.shift == 3'h0)
		else $error("coarse request with a shift");
	a_addr_default: assert property (
		RECALL_REQ |-> DEVICE_ADDR == 8'ha2) else $error("address not default");
	a_run_recall: assert property (
		RECALL_REQ && RECALL_DONE && SUPPLY_ABOVE_ANALOG
		|=> ANALOG_ENABLE && !RECALL_REQ) else $error("no run after recall");
	a_brown_off: assert property (
		ANALOG_ENABLE && !SUPPLY_ABOVE_ANALOG |=> !ANALOG_ENABLE)
		else $error("analog kept on at low supply");
	a_brown_back: assert property (
		seen_run && !ANALOG_ENABLE && SUPPLY_ABOVE_ANALOG |=> ANALOG_ENABLE)
		else $error("no prompt resume after brown-out");
	a_oe_idle: assert property (
		!ANALOG_ENABLE [*2] |-> PDM_OE == 4'h0) else $error("pins driven off");
	a_oe_init: assert property (
		PDM_OE != 4'h0 |-> run_cnt > INIT_CYCLES) else $error("pins driven early");
	a_fault_off: assert property (
		!ANALOG_ENABLE [*2] |-> TX_FAULT) else $error("fault low when off");
	a_alarm_clear: assert property (
		$fell(SUPPLY_LOW_ALARM) |-> $past(VCC_CONV_DONE)
		|| $past(VCC_CONV_DONE, 2) || !$past(ANALOG_ENABLE, 2))
		else $error("supply alarm cleared without conversion");
	// Main scenarios reached
	c_coarse: cover property (CONV_REQ ##[1:20] CONV_REQ);
	c_brown: cover property (seen_run && !ANALOG_ENABLE);
	c_pins: cover property ($rose(PDM_OE[0]));
endmodule // mardc_props

bind mardc_top mardc_props #(.INIT_CYCLES(INIT_CYCLES)) u_props (
	.CLK(CLK),
	.SRST(SRST),
	.SUPPLY_ABOVE_ANALOG(SUPPLY_ABOVE_ANALOG),
	.RECALL_REQ(RECALL_REQ),
	.RECALL_DONE(RECALL_DONE),
	.ANALOG_ENABLE(ANALOG_ENABLE),
	.DEVICE_ADDR(DEVICE_ADDR),
	.THIRD_MONITOR_CHANNEL_SLOT(THIRD_MONITOR_CHANNEL_SLOT),
	.CONV_REQ(CONV_REQ),
	.CONV_SET(CONV_SET),
	.CONV_DONE(CONV_DONE),
	.VCC_CONV_DONE(VCC_CONV_DONE),
	.TX_FAULT(TX_FAULT),
	.SUPPLY_LOW_ALARM(SUPPLY_LOW_ALARM),
	.PDM_OE(PDM_OE)
);

// *** tb/tb_top.sv ***
`define CHK(a, e) \
	begin \
		comparisons++; \
		if ((a) !== (e)) \
		begin \
			n_mismatch++; \
			$display("ERROR %0t: got %h expected %h", $time, a, e); \
		end \
	end
module tb_top
	import mardc_pkg::*;
	;
	timeunit 1ns;
	timeprecision 100ps;
	localparam int INIT = 20;
	localparam logic [7:0] CFG_A [12] = '{8'h8c, 8'h8f, 8'h98, 8'h99,
		8'h9c, 8'h9d, 8'hb8, 8'hb9, 8'h8b, 8'h80, 8'hb4, 8'hb5};
	localparam logic [7:0] CFG_D [12] = '{8'h5c, 8'h03, 8'h11, 8'h11,
		8'h22, 8'h22, 8'h80, 8'h00, 8'h00, 8'h49, 8'h02, 8'hc5};
	localparam logic [7:0] LUT_P [8] = '{8'h04, 8'h04, 8'h04, 8'h04,
		8'h07, 8'h07, 8'h07, 8'h07};
	localparam logic [7:0] LUT_A [8] = '{8'ha9, 8'hfc, 8'h80, 8'hf8,
		8'h94, 8'hfc, 8'h80, 8'hf8};
	localparam logic [7:0] LUT_D [8] = '{8'h7b, 8'h2a, 8'h10, 8'h00,
		8'h40, 8'h10, 8'h20, 8'h01};
	localparam logic [2:0] R_CFG [9] = '{3'h0, 3'h0, 3'h0, 3'h0, 3'h0,
		3'h4, 3'h4, 3'h1, 3'h2};
	localparam logic [15:0] R_RAW [9] = '{16'h8000, 16'hfff8, 16'hf000,
		16'heff8, 16'hf000, 16'hfff8, 16'hf000, 16'hfff8, 16'h0100};
	localparam logic R_CRS [9] = '{1'b0, 1'b1, 1'b1, 1'b0, 1'b0, 1'b1,
		1'b0, 1'b0, 1'b1};
	logic clk = 1'b0, srst = 1'b1, supply = 1'b0, recall_done = 1'b0;
	logic [7:0] page = 8'h00, addr = 8'h00, wdata = 8'h00;
	logic wr = 1'b0, rd = 1'b0, slot = 1'b0, vcc_done = 1'b0;
	logic temp_done = 1'b0, fault = 1'b0;
	logic [15:0] vcc_value = 16'h0000, temp_value = 16'h0000;
	logic [15:0] fine_level = 16'h0000;
	logic [9:0] loop_code = 10'h155;
	logic recall_req, analog_en, conv_req, conv_done, tx_fault, low_alarm;
	logic [7:0] dev_addr, rdata, b;
	logic [15:0] conv_raw, w;
	logic [3:0] pdm_out, pdm_oe;
	mardc_conv_type conv_set;
	logic [10:0] ones [4];
	int n_mismatch = 0, comparisons = 0, cycles = 0;
	// Clock at 200 MHz
	always #2.5 clk = ~clk;
	// Device under test
	mardc_top #(.INIT_CYCLES(INIT)) u_dut (.CLK(clk), .SRST(srst),
		.SUPPLY_ABOVE_ANALOG(supply), .RECALL_REQ(recall_req),
		.RECALL_DONE(recall_done), .ANALOG_ENABLE(analog_en),
		.DEVICE_ADDR(dev_addr), .REG_PAGE(page), .REG_ADDR(addr),
		.REG_WR(wr), .REG_RD(rd), .REG_WDATA(wdata), .REG_RDATA(rdata),
		.THIRD_MONITOR_CHANNEL_SLOT(slot), .CONV_REQ(conv_req), .CONV_SET(conv_set),
		.CONV_DONE(conv_done), .CONV_RAW(conv_raw),
		.VCC_CONV_DONE(vcc_done), .VCC_CONV_VALUE(vcc_value),
		.TEMP_CONV_DONE(temp_done), .TEMP_VALUE(temp_value),
		.FAULT_IN(fault), .LOOP_CODE(loop_code), .TX_FAULT(tx_fault),
		.SUPPLY_LOW_ALARM(low_alarm), .PDM_OUT(pdm_out), .PDM_OE(pdm_oe));
	// Converter at the monitor input
	mardc_conv_model #(.LAG(3)) u_conv (.clk(clk), .req(conv_req),
		.set(conv_set), .fine_gain(16'h1111), .fine_level(fine_level),
		.coarse_level(16'h4321), .done(conv_done), .raw(conv_raw));
	// Cut a hung run short
	always @(posedge clk)
	begin
		cycles++;
		if (cycles == 20000)
		begin
			n_mismatch++;
			$display("ERROR %0t: run did not finish", $time);
			close_out();
		end
	end
	task automatic close_out();
		$display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
		if (n_mismatch == 0 && comparisons > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task automatic wr8(input logic [7:0] p, a, d);
		tick(1);
		page = p;
		addr = a;
		wdata = d;
		wr = 1'b1;
		tick(1);
		wr = 1'b0;
	endtask
	task automatic rd8(input logic [7:0] p, a);
		tick(1);
		page = p;
		addr = a;
		rd = 1'b1;
		tick(1);
		rd = 1'b0;
		tick(1);
		b = rdata;
	endtask
	task automatic rd16(input logic [7:0] p, a);
		rd8(p, a);
		w[15:8] = b;
		rd8(p, a + 8'h01);
		w[7:0] = b;
	endtask
	task automatic vcc_pulse(input logic [15:0] v);
		tick(1);
		vcc_value = v;
		vcc_done = 1'b1;
		tick(1);
		vcc_done = 1'b0;
		tick(3);
	endtask
	// New temperature, then count ones on each pin over 1024 cycles
	task automatic pdm_count(input logic [15:0] t);
		tick(1);
		temp_value = t;
		temp_done = 1'b1;
		tick(1);
		temp_done = 1'b0;
		tick(4);
		ones = '{default: 11'h000};
		repeat (1024)
		begin
			tick(1);
			for (int j = 0; j < 4; j++)
				ones[j] = ones[j] + {10'h000, pdm_out[j]};
		end
	endtask
	// Test sequence
	initial
	begin
		tick(4);
		srst = 1'b0;
		`CHK(dev_addr, 8'ha2)
		`CHK({tx_fault, low_alarm, pdm_oe}, 6'h30)
		wr8(8'h02, 8'h8b, 8'h07);
		rd8(8'h02, 8'h8b);
		`CHK(b, 8'h00)
		rd8(8'h00, 8'h6e);
		`CHK(b[2:0], 3'h7)
		rd8(8'h00, 8'h10);
		`CHK(b, 8'h00)
		$display("test reset done");
		supply = 1'b1;
		tick(2);
		`CHK(recall_req, 1'b1)
		foreach (CFG_A[i])
			wr8(8'h02, CFG_A[i], CFG_D[i]);
		recall_done = 1'b1;
		tick(1);
		recall_done = 1'b0;
		tick(1);
		`CHK({analog_en, recall_req, dev_addr}, 10'h25c)
		rd8(8'h00, 8'h6e);
		`CHK(b[0], 1'b1)
		vcc_pulse(16'h7fff);
		`CHK(low_alarm, 1'b1)
		vcc_pulse(16'h8001);
		`CHK(low_alarm, 1'b0)
		tick(INIT);
		rd8(8'h00, 8'h6e);
		`CHK(b[0], 1'b0)
		`CHK(pdm_oe, 4'hf)
		$display("test power-up done");
		for (int k = 0; k < 9; k++)
		begin
			wr8(8'h02, 8'h8b, {5'h00, R_CFG[k]});
			fine_level = R_RAW[k];
			tick(1);
			slot = 1'b1;
			tick(1);
			slot = 1'b0;
			tick(20);
			rd16(8'h00, 8'h68);
			`CHK(w, R_CRS[k] ? 16'h4321 : R_RAW[k] >> 3)
			rd8(8'h00, 8'h6f);
			`CHK(b[0], R_CRS[k])
		end
		wr8(8'h00, 8'h68, 8'hff);
		rd16(8'h00, 8'h68);
		`CHK(w, 16'h4321)
		$display("test ranging done");
		foreach (LUT_P[i])
			wr8(LUT_P[i], LUT_A[i], LUT_D[i]);
		pdm_count(16'h2b00);
		`CHK(ones[0], 11'h07b + 11'h004 * 11'h02a)
		`CHK(ones[1], {1'b0, loop_code})
		`CHK(ones[2], 11'h2c5)
		`CHK(ones[3], 11'h040 + 11'h004 * 11'h010)
		pdm_count(16'hc400);
		`CHK(ones[0], 11'h010)
		`CHK(ones[3], 11'h020 + 11'h004 * 11'h001)
		$display("test outputs done");
		supply = 1'b0;
		tick(3);
		`CHK({analog_en, tx_fault, low_alarm, pdm_oe}, 7'h30)
		rd8(8'h02, 8'h8f);
		`CHK(b, 8'h03)
		supply = 1'b1;
		tick(4);
		`CHK({analog_en, pdm_oe}, 5'h1f)
		$display("test brown-out done");
		// Latch mode: no latching before a supply conversion above limit
		wr8(8'h02, 8'h8b, 8'h08);
		fault = 1'b1;
		tick(2);
		fault = 1'b0;
		tick(3);
		`CHK(tx_fault, 1'b0)
		vcc_pulse(16'h8001);
		fault = 1'b1;
		tick(2);
		fault = 1'b0;
		tick(3);
		`CHK(tx_fault, 1'b1)
		wr8(8'h02, 8'h8b, 8'h00);
		tick(2);
		`CHK(tx_fault, 1'b0)
		$display("test fault latch done");
		srst = 1'b1;
		tick(4);
		srst = 1'b0;
		`CHK(dev_addr, 8'ha2)
		rd8(8'h02, 8'h8f);
		`CHK(b, 8'h00)
		`CHK(recall_req, 1'b1)
		$display("test second reset done");
		close_out();
	end
endmodule // tb_top
